// ### hw/dhls_pkg.sv
// Function
// - Perpendicular output goes low when sampled field passes the operate threshold southward.
// - Lateral output goes low when sampled lateral field passes the operate threshold.
// - A channel output returns high when north field passes the release threshold.
// - Each output holds its last state when the field is removed.
// - Both outputs start low at power-up, even inside the hysteresis band.
// - Power-on delay ends within 48 us; outputs stay low until then.
// - Both channels share one sensing path, each sampled for 16 us.
// - A crossing in a channel's own period updates at that period's end.
// - A crossing during the other channel's period updates after the next own period.
// - The same operate and release thresholds apply to every sensed axis.
// - Hysteresis is operate minus release, between 15 and 68 gauss.
// - The X-axis polarity sense is inverted between the two package styles.
// - After power-on the lateral channel responds before the perpendicular channel.
package dhls_pkg;
  localparam int CLK_MHZ = 125;
  localparam int SAMPLE_US = 16;
  localparam int SAMPLE_CYC = SAMPLE_US * CLK_MHZ;
  localparam int PON_US = 32;
  localparam int PON_CYC = PON_US * CLK_MHZ;
  localparam int PON_MAX_US = 48;
  localparam int PON_MAX_CYC = PON_MAX_US * CLK_MHZ;
  localparam int FIELD_W = 12;
  localparam logic signed [11:0] OP_RST = 12'sh011;
  localparam logic signed [11:0] RP_RST = -12'sh011;
  localparam logic signed [11:0] HYS_MIN = 12'sh00F;
  localparam logic signed [11:0] HYS_MAX = 12'sh044;
  localparam logic [15:0] CNT_W0 = 16'h0000;

  typedef enum logic [1:0] {
    DHLS_PON,
    DHLS_LAT,
    DHLS_PERP
  } dhls_state_t;

  typedef struct packed {
    dhls_state_t st;
    logic [15:0] cnt;
    logic perp_out;
    logic lat_out;
    logic first_done;
  } dhls_regs_t;
endpackage

// ### hw/dhls_sampler.sv
module dhls_sampler #(
  parameter int PON_CYCLES = dhls_pkg::PON_CYC,
  parameter int SAMPLE_CYCLES = dhls_pkg::SAMPLE_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic signed [11:0] perp_field,
  input wire logic signed [11:0] lat_field,
  input wire logic x_axis_variant,
  input wire logic through_hole_pkg,
  input wire logic signed [11:0] operate_threshold,
  input wire logic signed [11:0] release_threshold,
  output logic perpendicular_axis_output,
  output logic lateral_axis_output,
  output logic sense_lateral,
  output logic outputs_valid
);
  // Field words come from the analog converter, so they are synchronised before use.
  logic signed [11:0] perp_s1_r, perp_s2_r, lat_s1_r, lat_s2_r;
  logic xv_s1_r, xv_s2_r, th_s1_r, th_s2_r;
  dhls_pkg::dhls_regs_t q_r, q_nxt;
  logic signed [11:0] fld;
  logic hit_op, hit_rp, cur;
  // A crossing can wait up to two periods for its channel's turn, so fast fields skew duty cycle.
  // Third stage and held copies of the field words.
  logic signed [11:0] perp_s3_r, lat_s3_r, perp_hold_r, lat_hold_r;

  // The lateral turn is decoded in several places, so it lives in one function.
  function automatic logic lat_turn(input dhls_pkg::dhls_state_t st);
    return st == dhls_pkg::DHLS_LAT;
  endfunction

  always_ff @(posedge ref_clk) begin
    perp_s1_r <= perp_field;
    perp_s2_r <= perp_s1_r;
    lat_s1_r <= lat_field;
    lat_s2_r <= lat_s1_r;
    perp_s3_r <= perp_s2_r;
    lat_s3_r <= lat_s2_r;
    // Bits of a word may land a cycle apart, so a word is taken only after two equal samples.
    // This costs two cycles of latency, well inside a sampling period.
    if (perp_s2_r == perp_s3_r) begin
      perp_hold_r <= perp_s3_r;
    end
    if (lat_s2_r == lat_s3_r) begin
      lat_hold_r <= lat_s3_r;
    end
    xv_s1_r <= x_axis_variant;
    xv_s2_r <= xv_s1_r;
    th_s1_r <= through_hole_pkg;
    th_s2_r <= th_s1_r;
  end

  always_comb begin
    // The shared path sees only the channel being sampled.
    fld = perp_hold_r;
    if (lat_turn(q_r.st)) begin
      fld = lat_hold_r;
      // X sense flips between package styles.
      if (xv_s2_r && th_s2_r) begin
        fld = -lat_hold_r;
      end
    end
    // Same thresholds for every axis.
    hit_op = fld > operate_threshold;
    hit_rp = fld < release_threshold;
  end

  always_comb begin
    q_nxt = q_r;
    q_nxt.cnt = q_r.cnt + 16'h0001;
    cur = lat_turn(q_r.st) ? q_r.lat_out : q_r.perp_out;
    // Latching: no crossing means the output keeps its value.
    if (hit_op) begin
      cur = 1'b0;
    end else if (hit_rp) begin
      cur = 1'b1;
    end
    unique case (q_r.st)
      dhls_pkg::DHLS_PON: begin
        // Outputs held low until the delay expires.
        if (q_r.cnt >= 16'(PON_CYCLES - 1)) begin
          q_nxt.cnt = dhls_pkg::CNT_W0;
          q_nxt.st = dhls_pkg::DHLS_LAT;
        end
      end
      dhls_pkg::DHLS_LAT, dhls_pkg::DHLS_PERP: begin
        // Decision taken only from the last cycle of the period.
        if (q_r.cnt >= 16'(SAMPLE_CYCLES - 1)) begin
          q_nxt.cnt = dhls_pkg::CNT_W0;
          // Only the sampled channel is updated; order is fixed.
          if (lat_turn(q_r.st)) begin
            q_nxt.lat_out = cur;
            q_nxt.st = dhls_pkg::DHLS_PERP;
          end else begin
            q_nxt.perp_out = cur;
            q_nxt.first_done = 1'b1;
            q_nxt.st = dhls_pkg::DHLS_LAT;
          end
        end
      end
      default: begin
        // An illegal code resumes the round robin rather than hanging the sampler.
        q_nxt.st = dhls_pkg::DHLS_LAT;
        q_nxt.cnt = dhls_pkg::CNT_W0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      q_r.st <= dhls_pkg::DHLS_PON;
      q_r.cnt <= dhls_pkg::CNT_W0;
      q_r.perp_out <= 1'b0;
      q_r.lat_out <= 1'b0;
      q_r.first_done <= 1'b0;
      perpendicular_axis_output <= 1'b0;
      lateral_axis_output <= 1'b0;
      sense_lateral <= 1'b0;
      outputs_valid <= 1'b0;
    end else begin
      q_r <= q_nxt;
      perpendicular_axis_output <= q_nxt.perp_out;
      lateral_axis_output <= q_nxt.lat_out;
      sense_lateral <= (q_nxt.st == dhls_pkg::DHLS_LAT);
      outputs_valid <= (q_nxt.st != dhls_pkg::DHLS_PON);
    end
  end

  int pon_cnt;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pon_cnt <= 0;
    end else if (!outputs_valid) begin
      pon_cnt <= pon_cnt + 1;
    end
  end

  sequence s_period_end;
    q_r.st != dhls_pkg::DHLS_PON && q_r.cnt == 16'(SAMPLE_CYCLES - 1);
  endsequence

  sequence s_lat_end;
    q_r.st == dhls_pkg::DHLS_LAT && q_r.cnt == 16'(SAMPLE_CYCLES - 1);
  endsequence

  sequence s_perp_end;
    q_r.st == dhls_pkg::DHLS_PERP && q_r.cnt == 16'(SAMPLE_CYCLES - 1);
  endsequence

  sequence s_pon_end;
    q_r.st == dhls_pkg::DHLS_PON && q_r.cnt == 16'(PON_CYCLES - 1);
  endsequence

  AST_PON_LOW: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !outputs_valid |-> !perpendicular_axis_output && !lateral_axis_output)
    else $error("Outputs not low during power-on.");
  AST_PON_TIME: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pon_cnt <= dhls_pkg::PON_MAX_CYC)
    else $error("Power-on delay too long.");
  AST_LAT_FIRST: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(outputs_valid) |-> sense_lateral)
    else $error("Lateral channel not sampled first.");
  AST_PERP_STABLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    q_r.st == dhls_pkg::DHLS_LAT |=> $stable(perpendicular_axis_output))
    else $error("Perpendicular output changed out of turn.");
  AST_LAT_STABLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    q_r.st == dhls_pkg::DHLS_PERP |=> $stable(lateral_axis_output))
    else $error("Lateral output changed out of turn.");
  AST_MID_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    q_r.cnt != 16'(SAMPLE_CYCLES - 1) |=>
      $stable(perpendicular_axis_output) && $stable(lateral_axis_output))
    else $error("Output updated mid period.");
  AST_OPERATE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_period_end and q_r.st == dhls_pkg::DHLS_PERP and hit_op |=> !perpendicular_axis_output)
    else $error("Perpendicular output did not turn on.");
  AST_RELEASE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_period_end and q_r.st == dhls_pkg::DHLS_LAT and hit_rp |=> lateral_axis_output)
    else $error("Lateral output did not turn off.");
  AST_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_period_end and q_r.st == dhls_pkg::DHLS_LAT and !hit_op and !hit_rp
      |=> $stable(lateral_axis_output))
    else $error("Lateral output not held.");
  AST_TOGGLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_period_end |=> $changed(sense_lateral))
    else $error("Channel did not alternate.");

  // The checks below cover the channel that the checks above leave out, and the sequencing.
  AST_LAT_OPERATE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_lat_end and hit_op |=> !lateral_axis_output)
    else $error("Lateral output did not turn on.");
  AST_PERP_RELEASE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_perp_end and hit_rp and !hit_op |=> perpendicular_axis_output)
    else $error("Perpendicular output did not turn off.");
  AST_PERP_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_perp_end and !hit_op and !hit_rp |=> $stable(perpendicular_axis_output))
    else $error("Perpendicular output not held.");
  AST_PON_EXIT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_pon_end |=> outputs_valid && sense_lateral)
    else $error("Power-on did not hand over to the lateral channel.");
  AST_PON_CNT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    q_r.st == dhls_pkg::DHLS_PON |-> q_r.cnt <= 16'(PON_CYCLES - 1))
    else $error("Power-on count overran.");
  AST_VALID_KEPT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    outputs_valid |=> outputs_valid)
    else $error("Outputs dropped out of the valid state.");
  AST_VALID_STATE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    outputs_valid == (q_r.st != dhls_pkg::DHLS_PON))
    else $error("Valid flag disagrees with the sampler state.");
  AST_PERIOD_LEN: assert property (@(posedge ref_clk) disable iff (!rst_n)
    q_r.st != dhls_pkg::DHLS_PON |-> q_r.cnt <= 16'(SAMPLE_CYCLES - 1))
    else $error("Sampling period overran.");
  AST_SENSE_STATE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sense_lateral == lat_turn(q_r.st))
    else $error("Lateral sense flag disagrees with the sampler state.");
  AST_LAT_TO_PERP: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_lat_end |=> q_r.st == dhls_pkg::DHLS_PERP)
    else $error("Lateral period not followed by perpendicular period.");
  AST_PERP_TO_LAT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_perp_end |=> q_r.st == dhls_pkg::DHLS_LAT)
    else $error("Perpendicular period not followed by lateral period.");
  AST_FIRST_STICKY: assert property (@(posedge ref_clk) disable iff (!rst_n)
    q_r.first_done |=> q_r.first_done)
    else $error("First round flag cleared without reset.");
  AST_PERP_AFTER_LAT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $changed(perpendicular_axis_output) |-> q_r.first_done)
    else $error("Perpendicular channel responded before the lateral one.");
endmodule

// ### testbench/dhls_quad_ctrl.sv
module dhls_quad_ctrl (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic chan_a,
  input wire logic chan_b,
  input wire logic valid,
  output logic signed [15:0] position
);
  timeunit 1ns;
  timeprecision 1ps;
  logic a_r;
  // Both lines are ignored until valid, so power-on lows never count as motion.
  always @(posedge ref_clk) begin
    if (!rst_n || !valid) begin
      a_r <= chan_a;
      position <= 16'sh0000;
    end else begin
      a_r <= chan_a;
      // Position steps on each chan_a edge; direction comes from the quadrature phase of the two lines.
      if (a_r != chan_a) begin
        position <= (chan_a ^ chan_b) ? position + 16'sh0001 : position - 16'sh0001;
      end
    end
  end
endmodule

// ### testbench/dhls_sampler_bench.sv
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module dhls_sampler_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PON = 20;
  localparam int SP = 10;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic signed [11:0] pf = -12'sh064;
  logic signed [11:0] lf = -12'sh064;
  logic signed [11:0] op_th = 12'sh011;
  logic signed [11:0] rp_th = -12'sh011;
  logic xv = 1'b0;
  logic th = 1'b0;
  logic pa, la, sl, ov;
  logic signed [15:0] pos;
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;
  dhls_sampler #(.PON_CYCLES(PON), .SAMPLE_CYCLES(SP)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
    .perp_field(pf), .lat_field(lf), .x_axis_variant(xv), .through_hole_pkg(th),
    .operate_threshold(op_th), .release_threshold(rp_th), .perpendicular_axis_output(pa),
    .lateral_axis_output(la), .sense_lateral(sl), .outputs_valid(ov));
  dhls_quad_ctrl ctrl_u (.ref_clk(ref_clk), .rst_n(rst_n), .chan_a(pa), .chan_b(la),
    .valid(ov), .position(pos));
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic end_sim();
    if (failures == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      failures++;
      end_sim();
    end
  end
  // Waits for the sampler to hand over to the other channel, which is when results land.
  task automatic next_p();
    logic s;
    s = sl;
    repeat (3 * SP) begin
      @(negedge ref_clk);
      if (sl !== s) return;
    end
    `CHK(sl, ~s)
  endtask
  task automatic power_on();
    repeat (PON - 2) begin
      @(negedge ref_clk);
      `CHK(pa, 1'b0)
      `CHK(la, 1'b0)
      `CHK(ov, 1'b0)
    end
    repeat (6 * 125) if (ov !== 1'b1) @(negedge ref_clk);
    `CHK(ov, 1'b1)
    `CHK(sl, 1'b1)
    `CHK(pos, 16'sh0000)
  endtask
  task automatic release_then_operate();
    next_p();
    `CHK(la, 1'b1)
    `CHK(pa, 1'b0)
    next_p();
    `CHK(pa, 1'b1)
    pf = 12'sh064;
    next_p();
    `CHK(pa, 1'b1)
    `CHK(pos, -16'sh0001)
    next_p();
    `CHK(pa, 1'b0)
    lf = 12'sh064;
    next_p();
    `CHK(la, 1'b0)
    `CHK(pos, 16'sh0000)
  endtask
  task automatic hold_and_glitch();
    pf = 12'sh000;
    lf = 12'sh000;
    next_p();
    next_p();
    `CHK({pa, la}, 2'b00)
    pf = -12'sh064;
    repeat (3) @(negedge ref_clk);
    pf = 12'sh000;
    next_p();
    `CHK(pa, 1'b0)
  endtask
  task automatic x_polarity();
    xv = 1'b1;
    th = 1'b1;
    lf = 12'sh064;
    next_p();
    `CHK(la, 1'b1)
    th = 1'b0;
    next_p();
    next_p();
    `CHK(la, 1'b0)
    xv = 1'b0;
    th = 1'b1;
    next_p();
    next_p();
    `CHK(la, 1'b0)
  endtask
  task automatic threshold_window();
    op_th = 12'sh020;
    rp_th = -12'sh020;
    pf = -12'sh01E;
    next_p();
    `CHK(pa, 1'b0)
    pf = -12'sh021;
    next_p();
    next_p();
    `CHK(pa, 1'b1)
    pf = 12'sh020;
    next_p();
    next_p();
    `CHK(pa, 1'b1)
    pf = 12'sh021;
    next_p();
    next_p();
    `CHK(pa, 1'b0)
    op_th = 12'sh011;
    rp_th = -12'sh011;
  endtask
  task automatic reset_in_band();
    pf = -12'sh064;
    lf = -12'sh064;
    next_p();
    next_p();
    `CHK({pa, la}, 2'b11)
    pf = 12'sh000;
    lf = 12'sh000;
    rst_n = 1'b0;
    repeat (10) @(negedge ref_clk);
    rst_n = 1'b1;
    power_on();
    next_p();
    next_p();
    `CHK({pa, la}, 2'b00)
  endtask
  initial begin
    repeat (10) @(negedge ref_clk);
    rst_n = 1'b1;
    power_on();
    release_then_operate();
    hold_and_glitch();
    x_polarity();
    threshold_window();
    reset_in_band();
    end_sim();
  end
endmodule
